//--- common/aluf_pkg.sv
// constants and types shared by the flag and operand address block
package aluf_pkg;
  // register byte offsets on the bus
  localparam logic [7:0] ADDR_FLAGS  = 8'h00;
  localparam logic [7:0] ADDR_BANK   = 8'h04;
  localparam logic [7:0] ADDR_WREG   = 8'h08;
  localparam logic [7:0] ADDR_FILE   = 8'h0C;
  localparam logic [7:0] ADDR_PTR0   = 8'h10;
  localparam logic [7:0] ADDR_PTR1   = 8'h14;
  localparam logic [7:0] ADDR_PTR2   = 8'h18;
  localparam logic [7:0] ADDR_CMD    = 8'h1C;
  localparam logic [7:0] ADDR_RESULT = 8'h20;
  localparam logic [7:0] ADDR_DADDR  = 8'h24;
  localparam logic [7:0] ADDR_TARGET = 8'h28;
  // flag bit positions inside alu_flags
  localparam int FLG_N  = 4;
  localparam int FLG_V  = 3;
  localparam int FLG_Z  = 2;
  localparam int FLG_DC = 1;
  localparam int FLG_C  = 0;
  // which flags each class of operation rewrites
  localparam logic [4:0] MASK_ARITH = 5'h1F;
  localparam logic [4:0] MASK_LOGIC = 5'h14;
  localparam logic [4:0] MASK_ROT   = 5'h17;
  localparam logic [4:0] MASK_CLR   = 5'h04;
  localparam logic [4:0] MASK_NONE  = 5'h00;
  // command word field positions
  localparam int CMD_OP_LSB   = 0;
  localparam int CMD_D_BIT    = 4;
  localparam int CMD_A_BIT    = 5;
  localparam int CMD_PSEL_LSB = 6;
  localparam int CMD_MODE_LSB = 8;
  localparam int CMD_F_LSB    = 12;
  localparam int CMD_HI_LSB   = 20;
  // data space landmarks
  localparam logic [11:0] FLAGS_FILE_ADDR = 12'hFF0;
  localparam logic [7:0]  ACCESS_SPLIT    = 8'h60;
  localparam logic [7:0]  LITOFS_MAX      = 8'h5F;
  localparam logic [3:0]  ACCESS_HI_BANK  = 4'hF;
  // reset values (flags are unknown at power up, zero chosen)
  localparam logic [4:0]  FLAGS_RST = 5'h00;
  localparam logic [3:0]  BANK_RST  = 4'h0;
  localparam logic [7:0]  BYTE_RST  = 8'h00;
  localparam logic [11:0] PTR_RST   = 12'h000;
  localparam logic [31:0] CMD_RST   = 32'h0000_0000;
  // axi responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // operations
  typedef enum logic [3:0] {
    OP_ADD, OP_SUB, OP_AND, OP_IOR, OP_XOR, OP_RLC, OP_RRC,
    OP_CLR, OP_MOV, OP_BSET, OP_BCLR, OP_SWAP, OP_GOTO
  } aluf_op_t;
  // operand addressing modes
  typedef enum logic [2:0] {
    MODE_DIRECT, MODE_FULL, MODE_PLAIN, MODE_POST_INCREMENT_OPERAND,
    MODE_POST_DECREMENT_OPERAND, MODE_PRE_INCREMENT_OPERAND, MODE_INDEXED
  } aluf_mode_t;
endpackage

//--- src/aluf_core.sv
// flag register, alu and operand address generator behind an axi4-lite slave
//
// Functional notes
// - flags: n4 v3 z2 dc1 c0, top zero
// - flag-updating op onto flags: logic wins
// - clear onto flags sets only zero
// - negative follows result msb
// - overflow on signed sign change
// - zero set when result is zero
// - add/sub digit carry from bit 3
// - add/sub carry from msb
// - subtract adds complement; carry means no borrow
// - rotates load carry and digit carry
// - jump carries a 20-bit target
// - file address is command word bits 19:12
// - access bit one: bank plus file address
// - access bit zero: fixed access bank
// - full 12-bit address ignores bank
// - destination bit picks file or working
// - indirect address from pointer pair
// - virtual operands adjust pointer as side effect
// - literal offset mode only with config bit
// - pointer is 12 bits, upper nibble unused
// - plain, post inc/dec, pre inc, indexed
// - pointer carries across bytes, flags untouched
// - indirect ignores bank and access bit
`timescale 1ns/100ps
module aluf_core (
  input  wire logic        clock,
  input  wire logic        arst_n,
  input  wire logic        extended_isa_config_bit,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic             file_we,
  output logic [11:0]      file_addr,
  output logic [7:0]       file_wdata,
  output logic [19:0]      branch_target
);
  ////////////////////////////////////////////////////////////////////////
  // state
  logic [4:0]  flags_ff;          // implemented flag bits
  logic [3:0]  bank_ff;           // bank_select_reg
  logic [7:0]  wreg_ff;           // working register
  logic [7:0]  file_ff;           // file operand value from data memory
  logic [11:0] ptr_ff [3];        // pointer_pair 0..2
  logic [31:0] cmd_ff;            // last command word
  logic        exec_ff;           // one-cycle execute pulse
  logic [7:0]  result_ff;         // last alu result
  logic [11:0] daddr_ff;          // last operand address
  logic [19:0] target_ff;         // last jump target
  logic        we_ff;             // file write strobe
  // bus state
  logic        aw_held_ff;
  logic [7:0]  aw_addr_ff;
  logic        w_held_ff;
  logic [31:0] w_data_ff;
  logic [3:0]  w_strb_ff;
  logic        bvalid_ff;
  logic [1:0]  bresp_ff;
  logic        rvalid_ff;
  logic [31:0] rdata_ff;
  logic [1:0]  rresp_ff;
  ////////////////////////////////////////////////////////////////////////
  // command decode
  aluf_pkg::aluf_op_t   op_c;
  aluf_pkg::aluf_mode_t mode_c;
  logic [7:0]  fa_c;              // 8-bit file address field
  logic [11:0] hi_c;              // upper command field
  logic [1:0]  pidx_c;            // selected pointer
  logic [11:0] sel_ptr_c;         // value of selected pointer
  logic        acc_c;             // access-select bit
  assign op_c   = aluf_pkg::aluf_op_t'(cmd_ff[aluf_pkg::CMD_OP_LSB +: 4]);
  assign mode_c = aluf_pkg::aluf_mode_t'(cmd_ff[aluf_pkg::CMD_MODE_LSB +: 3]);
  assign fa_c   = cmd_ff[aluf_pkg::CMD_F_LSB +: 8];
  assign hi_c   = cmd_ff[aluf_pkg::CMD_HI_LSB +: 12];
  assign acc_c  = cmd_ff[aluf_pkg::CMD_A_BIT];
  // a select of three folds onto pointer two: only three pairs exist
  assign pidx_c = (cmd_ff[aluf_pkg::CMD_PSEL_LSB +: 2] == 2'h3) ? 2'h2 : cmd_ff[aluf_pkg::CMD_PSEL_LSB +: 2];
  assign sel_ptr_c = ptr_ff[pidx_c];
  ////////////////////////////////////////////////////////////////////////
  // operand address generation
  logic [11:0] addr_c;
  always_comb begin
    addr_c = {aluf_pkg::ACCESS_HI_BANK, fa_c};
    case (mode_c)
      aluf_pkg::MODE_DIRECT: begin
        if (extended_isa_config_bit && !acc_c && fa_c <= aluf_pkg::LITOFS_MAX) begin
          addr_c = ptr_ff[2] + {4'h0, fa_c};
        end else if (acc_c) begin
          addr_c = {bank_ff, fa_c};
        end else if (fa_c < aluf_pkg::ACCESS_SPLIT) begin
          addr_c = {4'h0, fa_c};
        end else begin
          addr_c = {aluf_pkg::ACCESS_HI_BANK, fa_c};
        end
      end
      aluf_pkg::MODE_FULL:    addr_c = {hi_c[3:0], fa_c};
      // pointer modes never look at bank or access bit
      aluf_pkg::MODE_PLAIN,
      aluf_pkg::MODE_POST_INCREMENT_OPERAND,
      aluf_pkg::MODE_POST_DECREMENT_OPERAND: addr_c = sel_ptr_c;
      aluf_pkg::MODE_PRE_INCREMENT_OPERAND:  addr_c = sel_ptr_c + 12'h001;
      aluf_pkg::MODE_INDEXED: addr_c = sel_ptr_c + {{4{wreg_ff[7]}}, wreg_ff};
      default:                addr_c = {aluf_pkg::ACCESS_HI_BANK, fa_c};
    endcase
  end
  ////////////////////////////////////////////////////////////////////////
  // alu
  logic        src_flags_c;       // operand is the flag register itself
  logic [7:0]  fv_c;              // file operand
  logic        sub_c;
  logic [7:0]  addend_c;
  logic [8:0]  sum_c;
  logic [4:0]  nib_c;
  logic        ovf_c;
  logic [7:0]  res_c;
  logic [4:0]  upd_c;             // flags rewritten by this op
  logic [4:0]  fl_c;              // freshly derived flags
  logic        to_file_c;
  logic        to_flags_c;
  logic [7:0]  bitmask_c;
  assign src_flags_c = (addr_c == aluf_pkg::FLAGS_FILE_ADDR);
  assign fv_c     = src_flags_c ? {3'h0, flags_ff} : file_ff;
  assign sub_c    = (op_c == aluf_pkg::OP_SUB);
  assign addend_c = sub_c ? ~wreg_ff : wreg_ff;
  assign sum_c    = {1'b0, fv_c} + {1'b0, addend_c} + {8'h00, sub_c};
  assign nib_c    = {1'b0, fv_c[3:0]} + {1'b0, addend_c[3:0]} + {4'h0, sub_c};
  // signed overflow: like-signed inputs give a result of the other sign
  assign ovf_c    = (fv_c[7] == addend_c[7]) && (sum_c[7] != fv_c[7]);
  assign bitmask_c = 8'h01 << hi_c[2:0];
  // result of each operation; clear, goto and unused codes give zero
  always_comb begin
    case (op_c)
      aluf_pkg::OP_ADD, aluf_pkg::OP_SUB: res_c = sum_c[7:0];
      aluf_pkg::OP_AND:  res_c = fv_c & wreg_ff;
      aluf_pkg::OP_IOR:  res_c = fv_c | wreg_ff;
      aluf_pkg::OP_XOR:  res_c = fv_c ^ wreg_ff;
      aluf_pkg::OP_RLC:  res_c = {fv_c[6:0], flags_ff[aluf_pkg::FLG_C]};
      aluf_pkg::OP_RRC:  res_c = {flags_ff[aluf_pkg::FLG_C], fv_c[7:1]};
      aluf_pkg::OP_MOV:  res_c = fv_c;
      aluf_pkg::OP_BSET: res_c = fv_c | bitmask_c;
      aluf_pkg::OP_BCLR: res_c = fv_c & ~bitmask_c;
      aluf_pkg::OP_SWAP: res_c = {fv_c[3:0], fv_c[7:4]};
      default:           res_c = 8'h00;
    endcase
  end
  // which flags the operation rewrites; moves and bit ops touch none
  always_comb begin
    case (op_c)
      aluf_pkg::OP_ADD, aluf_pkg::OP_SUB:                  upd_c = aluf_pkg::MASK_ARITH;
      aluf_pkg::OP_AND, aluf_pkg::OP_IOR, aluf_pkg::OP_XOR: upd_c = aluf_pkg::MASK_LOGIC;
      aluf_pkg::OP_RLC, aluf_pkg::OP_RRC:                  upd_c = aluf_pkg::MASK_ROT;
      aluf_pkg::OP_CLR:                                    upd_c = aluf_pkg::MASK_CLR;
      default:                                             upd_c = aluf_pkg::MASK_NONE;
    endcase
  end
  // flag derivation, used only where upd_c selects it
  always_comb begin
    fl_c[aluf_pkg::FLG_N]  = res_c[7];
    fl_c[aluf_pkg::FLG_V]  = ovf_c;
    fl_c[aluf_pkg::FLG_Z]  = (res_c == 8'h00);
    // rotates load end bits of the source, add and subtract their carry outs
    fl_c[aluf_pkg::FLG_DC] = (op_c == aluf_pkg::OP_RLC) ? fv_c[3]
                             : (op_c == aluf_pkg::OP_RRC) ? fv_c[4] : nib_c[4];
    fl_c[aluf_pkg::FLG_C]  = (op_c == aluf_pkg::OP_RLC) ? fv_c[7]
                             : (op_c == aluf_pkg::OP_RRC) ? fv_c[0] : sum_c[8];
  end
  // destination: clear and bit ops write the file implicitly, goto writes nothing
  assign to_file_c = (op_c == aluf_pkg::OP_CLR) || (op_c == aluf_pkg::OP_BSET) || (op_c == aluf_pkg::OP_BCLR)
                     || ((op_c != aluf_pkg::OP_GOTO) && cmd_ff[aluf_pkg::CMD_D_BIT]);
  assign to_flags_c = to_file_c && src_flags_c;
  ////////////////////////////////////////////////////////////////////////
  // bus helpers
  function automatic logic [31:0] view(input logic [7:0] a);
    case (a)
      aluf_pkg::ADDR_FLAGS:  view = {27'h0, flags_ff};
      aluf_pkg::ADDR_BANK:   view = {28'h0, bank_ff};
      aluf_pkg::ADDR_WREG:   view = {24'h0, wreg_ff};
      aluf_pkg::ADDR_FILE:   view = {24'h0, file_ff};
      aluf_pkg::ADDR_PTR0:   view = {20'h0, ptr_ff[0]};
      aluf_pkg::ADDR_PTR1:   view = {20'h0, ptr_ff[1]};
      aluf_pkg::ADDR_PTR2:   view = {20'h0, ptr_ff[2]};
      aluf_pkg::ADDR_CMD:    view = cmd_ff;
      aluf_pkg::ADDR_RESULT: view = {24'h0, result_ff};
      aluf_pkg::ADDR_DADDR:  view = {20'h0, daddr_ff};
      aluf_pkg::ADDR_TARGET: view = {12'h0, target_ff};
      default:               view = 32'h0000_0000;
    endcase
  endfunction
  function automatic logic mapped(input logic [7:0] a);
    mapped = (a[1:0] == 2'h0) && (a <= aluf_pkg::ADDR_TARGET);
  endfunction
  logic        wr_go_c;           // both halves of a write are held
  logic [31:0] wmerge_c;          // write data merged under strobes
  logic        ar_go_c;
  assign wr_go_c = aw_held_ff && w_held_ff && !bvalid_ff;
  assign ar_go_c = s_axi_arvalid && !rvalid_ff;
  always_comb begin
    wmerge_c = view(aw_addr_ff);
    for (int i = 0; i < 4; i++) begin
      if (w_strb_ff[i]) begin
        wmerge_c[8*i +: 8] = w_data_ff[8*i +: 8];
      end
    end
  end
  // bus write and execute never meet: execute trails the command write by a cycle
  logic bw_c;
  assign bw_c = wr_go_c && !exec_ff;
  ////////////////////////////////////////////////////////////////////////
  // flag register
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      flags_ff <= aluf_pkg::FLAGS_RST;
    end else if (exec_ff && op_c != aluf_pkg::OP_GOTO) begin
      if (to_flags_c && upd_c == aluf_pkg::MASK_NONE) begin
        flags_ff <= res_c[4:0];
      end else begin
        // written data is dropped; flags the op does not derive keep their old value
        flags_ff <= (fl_c & upd_c) | (flags_ff & ~upd_c);
      end
    end else if (bw_c && aw_addr_ff == aluf_pkg::ADDR_FLAGS) begin
      flags_ff <= wmerge_c[4:0];
    end
  end
  // working register
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      wreg_ff <= aluf_pkg::BYTE_RST;
    end else if (exec_ff && !to_file_c && op_c != aluf_pkg::OP_GOTO) begin
      wreg_ff <= res_c;
    end else if (bw_c && aw_addr_ff == aluf_pkg::ADDR_WREG) begin
      wreg_ff <= wmerge_c[7:0];
    end
  end
  // bank select and file operand
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      bank_ff <= aluf_pkg::BANK_RST;
      file_ff <= aluf_pkg::BYTE_RST;
    end else if (bw_c) begin
      if (aw_addr_ff == aluf_pkg::ADDR_BANK) begin
        bank_ff <= wmerge_c[3:0];
      end
      if (aw_addr_ff == aluf_pkg::ADDR_FILE) begin
        file_ff <= wmerge_c[7:0];
      end
    end
  end
  // pointer pairs: side effects of virtual operands, or plain writes
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < 3; i++) begin
        ptr_ff[i] <= aluf_pkg::PTR_RST;
      end
    end else if (exec_ff) begin
      // 12-bit add: low byte rollover carries into the high byte
      case (mode_c)
        aluf_pkg::MODE_POST_INCREMENT_OPERAND: ptr_ff[pidx_c] <= sel_ptr_c + 12'h001;
        aluf_pkg::MODE_POST_DECREMENT_OPERAND: ptr_ff[pidx_c] <= sel_ptr_c - 12'h001;
        aluf_pkg::MODE_PRE_INCREMENT_OPERAND:  ptr_ff[pidx_c] <= sel_ptr_c + 12'h001;
        default:                ptr_ff[pidx_c] <= sel_ptr_c;
      endcase
    end else if (bw_c) begin
      if (aw_addr_ff == aluf_pkg::ADDR_PTR0) ptr_ff[0] <= wmerge_c[11:0];
      if (aw_addr_ff == aluf_pkg::ADDR_PTR1) ptr_ff[1] <= wmerge_c[11:0];
      if (aw_addr_ff == aluf_pkg::ADDR_PTR2) ptr_ff[2] <= wmerge_c[11:0];
    end
  end
  // command capture and execute pulse
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      cmd_ff  <= aluf_pkg::CMD_RST;
      exec_ff <= 1'b0;
    end else begin
      exec_ff <= bw_c && aw_addr_ff == aluf_pkg::ADDR_CMD;
      if (bw_c && aw_addr_ff == aluf_pkg::ADDR_CMD) begin
        cmd_ff <= wmerge_c;
      end
    end
  end
  // results, operand address, file write strobe and jump target
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      result_ff <= aluf_pkg::BYTE_RST;
      daddr_ff  <= aluf_pkg::PTR_RST;
      target_ff <= 20'h00000;
      we_ff     <= 1'b0;
    end else begin
      we_ff <= exec_ff && to_file_c;
      if (exec_ff && op_c == aluf_pkg::OP_GOTO) begin
        target_ff <= {hi_c, fa_c};
      end else if (exec_ff) begin
        result_ff <= res_c;
        daddr_ff  <= addr_c;
      end
    end
  end
  assign file_we       = we_ff;
  assign file_addr     = daddr_ff;
  assign file_wdata    = result_ff;
  assign branch_target = target_ff;
  ////////////////////////////////////////////////////////////////////////
  // axi4-lite write channel
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      aw_held_ff <= 1'b0;
      aw_addr_ff <= 8'h00;
      w_held_ff  <= 1'b0;
      w_data_ff  <= 32'h0000_0000;
      w_strb_ff  <= 4'h0;
      bvalid_ff  <= 1'b0;
      bresp_ff   <= aluf_pkg::RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_ff <= 1'b1;
        aw_addr_ff <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_ff <= 1'b1;
        w_data_ff <= s_axi_wdata;
        w_strb_ff <= s_axi_wstrb;
      end
      if (bw_c) begin
        aw_held_ff <= 1'b0;
        w_held_ff  <= 1'b0;
        bvalid_ff  <= 1'b1;
        bresp_ff   <= mapped(aw_addr_ff) ? aluf_pkg::RESP_OKAY : aluf_pkg::RESP_SLVERR;
      end else if (bvalid_ff && s_axi_bready) begin
        bvalid_ff <= 1'b0;
      end
    end
  end
  assign s_axi_awready = !aw_held_ff && !bvalid_ff;
  assign s_axi_wready  = !w_held_ff && !bvalid_ff;
  assign s_axi_bvalid  = bvalid_ff;
  assign s_axi_bresp   = bresp_ff;
  // axi4-lite read channel, answer one cycle after the address
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      rvalid_ff <= 1'b0;
      rdata_ff  <= 32'h0000_0000;
      rresp_ff  <= aluf_pkg::RESP_OKAY;
    end else if (ar_go_c) begin
      rvalid_ff <= 1'b1;
      rdata_ff  <= view(s_axi_araddr);
      rresp_ff  <= mapped(s_axi_araddr) ? aluf_pkg::RESP_OKAY : aluf_pkg::RESP_SLVERR;
    end else if (rvalid_ff && s_axi_rready) begin
      rvalid_ff <= 1'b0;
    end
  end
  assign s_axi_arready = !rvalid_ff;
  assign s_axi_rvalid  = rvalid_ff;
  assign s_axi_rdata   = rdata_ff;
  assign s_axi_rresp   = rresp_ff;
  ////////////////////////////////////////////////////////////////////////
  // assertions
  flags_pad_a: assert property (@(posedge clock) disable iff (!arst_n)
    rvalid_ff && $past(ar_go_c) && $past(s_axi_araddr) == aluf_pkg::ADDR_FLAGS
    |-> rdata_ff[31:5] == 27'h0) else $error("flag read shows upper bits");
  clear_zero_a: assert property (@(posedge clock) disable iff (!arst_n)
    exec_ff && op_c == aluf_pkg::OP_CLR && to_flags_c
    |=> flags_ff[aluf_pkg::FLG_Z] && flags_ff[4:3] == $past(flags_ff[4:3])
        && flags_ff[1:0] == $past(flags_ff[1:0])) else $error("clear onto flags wrong");
  neg_flag_a: assert property (@(posedge clock) disable iff (!arst_n)
    exec_ff && op_c == aluf_pkg::OP_ADD && !to_flags_c
    |=> flags_ff[aluf_pkg::FLG_N] == result_ff[7]) else $error("negative flag mismatch");
  zero_flag_a: assert property (@(posedge clock) disable iff (!arst_n)
    exec_ff && op_c == aluf_pkg::OP_XOR && !to_flags_c
    |=> flags_ff[aluf_pkg::FLG_Z] == (result_ff == 8'h00)) else $error("zero flag mismatch");
  borrow_sub_a: assert property (@(posedge clock) disable iff (!arst_n)
    exec_ff && op_c == aluf_pkg::OP_SUB && !to_flags_c
    |=> flags_ff[aluf_pkg::FLG_C] == ($past(fv_c) >= $past(wreg_ff))) else $error("borrow polarity wrong");
  ptr_post_increment_operand_a: assert property (@(posedge clock) disable iff (!arst_n)
    exec_ff && mode_c == aluf_pkg::MODE_POST_INCREMENT_OPERAND && op_c != aluf_pkg::OP_GOTO
    |=> daddr_ff == $past(sel_ptr_c) && ptr_ff[$past(pidx_c)] == daddr_ff + 12'h001)
    else $error("post increment wrong");
  bank_addr_a: assert property (@(posedge clock) disable iff (!arst_n)
    exec_ff && mode_c == aluf_pkg::MODE_DIRECT && acc_c && op_c != aluf_pkg::OP_GOTO
    |=> daddr_ff == {$past(bank_ff), $past(fa_c)}) else $error("banked address wrong");
  direct_write_a: assert property (@(posedge clock) disable iff (!arst_n)
    exec_ff && op_c == aluf_pkg::OP_BSET && to_flags_c
    |=> flags_ff == $past(res_c[4:0]) && file_we) else $error("direct flag write wrong");
  bresp_hold_a: assert property (@(posedge clock) disable iff (!arst_n)
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
endmodule

//--- test/aluf_mem_model.sv
// data memory model that absorbs result writes from the block
`timescale 1ns/100ps
module aluf_mem_model (
  input wire logic        clock,
  input wire logic        file_we,
  input wire logic [11:0] file_addr,
  input wire logic [7:0]  file_wdata
);
  logic [7:0] mem [0:4095]; // whole 12-bit data space
  ////////////////////////////////////////////////////////////
  // store only on the pulse, so a stale address between commands does no harm
  always @(posedge clock) begin
    if (file_we) begin
      mem[file_addr] <= file_wdata;
    end
  end
endmodule

//--- test/alu_flags_and_operand_addressing_tb.sv
// self-checking bench for the flag and operand address block
`timescale 1ns/100ps
module alu_flags_and_operand_addressing_tb;
  logic        clock, arst_n, file_we, ext_cfg;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [7:0]  s_axi_awaddr, s_axi_araddr, file_wdata;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [11:0] file_addr;
  logic [19:0] branch_target;
  int          bad_count, samples_checked, cyc;
  ////////////////////////////////////////////////////////////
  // literal offset mode stays off except in the scenario that tries it
  aluf_core dut_u (.clock, .arst_n, .extended_isa_config_bit(ext_cfg), .s_axi_wstrb(4'hF),
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .file_we, .file_addr, .file_wdata,
    .branch_target);
  aluf_mem_model mem_u (.clock, .file_we, .file_addr, .file_wdata);
  ////////////////////////////////////////////////////////////
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  // hang guard: the whole run needs well under a thousand cycles
  always @(posedge clock) begin
    cyc++;
    if (cyc == 5000) begin
      bad_count++;
      give_verdict();
    end
  end
  task automatic give_verdict();
    if (bad_count == 0 && samples_checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  ////////////////////////////////////////////////////////////
  // write: address and data offered together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    forever begin
      @(posedge clock);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    s_axi_bready <= 1'b0;
    // every write the bench makes lands on a mapped register
    chk("bresp", {30'h0, aluf_pkg::RESP_OKAY}, {30'h0, s_axi_bresp});
  endtask
  // read: data and response taken at the edge where rvalid is seen
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r, input string nm);
    @(posedge clock);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    forever begin
      @(posedge clock);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    s_axi_rready <= 1'b0;
    chk(nm, e, s_axi_rdata);
    chk("rresp", {30'h0, r}, {30'h0, s_axi_rresp});
  endtask
  function automatic logic [31:0] cw(aluf_pkg::aluf_op_t op, logic d, logic a, logic [1:0] ps,
    aluf_pkg::aluf_mode_t m, logic [7:0] f, logic [11:0] hi);
    return {hi, f, 1'b0, m, ps, a, d, op};
  endfunction
  ////////////////////////////////////////////////////////////
  // 0x88+0x88: signed overflow, both carries, positive nonzero result to working reg
  task automatic t_add();
    wr(aluf_pkg::ADDR_FILE, 32'h88);
    wr(aluf_pkg::ADDR_WREG, 32'h88);
    wr(aluf_pkg::ADDR_CMD, cw(aluf_pkg::OP_ADD, 0, 0, 0, aluf_pkg::MODE_DIRECT, 8'h10, 0));
    rd(aluf_pkg::ADDR_FLAGS, 32'h0B, 0, "add flags");
    rd(aluf_pkg::ADDR_WREG, 32'h10, 0, "sum in w");
    rd(aluf_pkg::ADDR_DADDR, 32'h010, 0, "access bank addr");
  endtask
  // 0-1 into banked file: borrow shows as cleared carry, negative result
  task automatic t_sub();
    wr(aluf_pkg::ADDR_FILE, 32'h00);
    wr(aluf_pkg::ADDR_WREG, 32'h01);
    wr(aluf_pkg::ADDR_BANK, 32'h5);
    wr(aluf_pkg::ADDR_CMD, cw(aluf_pkg::OP_SUB, 1, 1, 0, aluf_pkg::MODE_DIRECT, 8'h23, 0));
    rd(aluf_pkg::ADDR_FLAGS, 32'h10, 0, "sub flags");
    rd(aluf_pkg::ADDR_DADDR, 32'h523, 0, "banked addr");
    chk("mem 523", 32'hFF, {24'h0, mem_u.mem[12'h523]});
    rd(aluf_pkg::ADDR_WREG, 32'h01, 0, "w kept");
  endtask
  // rotate left through cleared carry: carry from bit 7, digit carry from bit 3
  task automatic t_rot();
    wr(aluf_pkg::ADDR_FILE, 32'h88);
    wr(aluf_pkg::ADDR_CMD, cw(aluf_pkg::OP_RLC, 0, 0, 0, aluf_pkg::MODE_DIRECT, 8'h10, 0));
    rd(aluf_pkg::ADDR_RESULT, 32'h10, 0, "rotated");
    rd(aluf_pkg::ADDR_FLAGS, 32'h03, 0, "rot flags");
    // 88 xor 10 gives 98: negative set, zero clear, carries kept
    wr(aluf_pkg::ADDR_CMD, cw(aluf_pkg::OP_XOR, 0, 0, 0, aluf_pkg::MODE_DIRECT, 8'h10, 0));
    rd(aluf_pkg::ADDR_FLAGS, 32'h13, 0, "xor flags");
  endtask
  // flag register as destination: clear sets only zero, add takes flags from logic
  task automatic t_flags();
    wr(aluf_pkg::ADDR_FLAGS, 32'hFB);
    rd(aluf_pkg::ADDR_FLAGS, 32'h1B, 0, "flags top zero");
    wr(aluf_pkg::ADDR_CMD, cw(aluf_pkg::OP_CLR, 1, 0, 0, aluf_pkg::MODE_FULL, 8'hF0, 12'h00F));
    rd(aluf_pkg::ADDR_FLAGS, 32'h1F, 0, "clear flags");
    rd(aluf_pkg::ADDR_DADDR, 32'hFF0, 0, "full addr");
    wr(aluf_pkg::ADDR_WREG, 32'hE1);
    wr(aluf_pkg::ADDR_CMD, cw(aluf_pkg::OP_ADD, 1, 0, 0, aluf_pkg::MODE_FULL, 8'hF0, 12'h00F));
    rd(aluf_pkg::ADDR_FLAGS, 32'h07, 0, "add onto flags");
    // bit set of bit 4 through the access bank onto the flags writes them directly
    wr(aluf_pkg::ADDR_CMD, cw(aluf_pkg::OP_BSET, 1, 0, 0, aluf_pkg::MODE_DIRECT, 8'hF0, 12'h004));
    rd(aluf_pkg::ADDR_FLAGS, 32'h17, 0, "bit set onto flags");
  endtask
  // pointer operands: post increment carries into high byte, indexed leaves pointer alone
  task automatic t_ptr();
    wr(aluf_pkg::ADDR_FILE, 32'h5A);
    wr(aluf_pkg::ADDR_PTR0, 32'h0FF);
    wr(aluf_pkg::ADDR_CMD, cw(aluf_pkg::OP_MOV, 1, 1, 0, aluf_pkg::MODE_POST_INCREMENT_OPERAND, 8'h33, 0));
    rd(aluf_pkg::ADDR_PTR0, 32'h100, 0, "ptr0 after inc");
    chk("mem 0ff", 32'h5A, {24'h0, mem_u.mem[12'h0FF]});
    rd(aluf_pkg::ADDR_FLAGS, 32'h17, 0, "flags untouched");
    wr(aluf_pkg::ADDR_WREG, 32'h80);
    wr(aluf_pkg::ADDR_PTR1, 32'h200);
    wr(aluf_pkg::ADDR_CMD, cw(aluf_pkg::OP_MOV, 1, 1, 1, aluf_pkg::MODE_INDEXED, 8'h33, 0));
    rd(aluf_pkg::ADDR_DADDR, 32'h180, 0, "indexed addr");
    rd(aluf_pkg::ADDR_PTR1, 32'h200, 0, "ptr1 kept");
  endtask
  // jump target, a read of an unmapped place, then literal offset off pointer two
  task automatic t_misc();
    wr(aluf_pkg::ADDR_CMD, cw(aluf_pkg::OP_GOTO, 0, 0, 0, aluf_pkg::MODE_DIRECT, 8'h12, 12'hABC));
    rd(8'h2C, 32'h0, aluf_pkg::RESP_SLVERR, "unmapped");
    chk("target pin", 32'hABC12, {12'h0, branch_target});
    wr(aluf_pkg::ADDR_PTR2, 32'h300);
    ext_cfg <= 1'b1;
    wr(aluf_pkg::ADDR_CMD, cw(aluf_pkg::OP_MOV, 0, 0, 0, aluf_pkg::MODE_DIRECT, 8'h10, 0));
    rd(aluf_pkg::ADDR_DADDR, 32'h310, 0, "literal offset addr");
    ext_cfg <= 1'b0;
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    {arst_n, ext_cfg, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    repeat (2) @(posedge clock);
    arst_n <= 1'b1;
    rd(aluf_pkg::ADDR_FLAGS, 32'h0, 0, "flags reset");
    t_add();
    t_sub();
    t_rot();
    t_flags();
    t_ptr();
    t_misc();
    give_verdict();
  end
endmodule
